//--- bench/fls_ctrl_tb.sv
`timescale 1ns/100ps
module fls_ctrl_tb;
    localparam int LAT = 40;
    localparam int OFF = 60;
    localparam int FLT = 30;
    localparam int QS  = 50;

    logic       clk;
    logic       resetn;
    logic       en_pin;
    logic       trig;
    logic       inh;
    logic       sink_low_in;
    logic       ovp_reached_in;
    logic       over_temp_in;
    logic       short_led_in;
    logic       device_on;
    logic       flash_drive;
    logic       flash_full;
    logic       movie_drive;
    logic [3:0] led_level;
    logic [1:0] flash_ratio;
    logic       test_current_on;
    logic       output_connect;
    logic       fault_latched;
    int         n_mismatch;
    int         checks_done;
    int         n;

    fls_host #(.LAT_CYC(LAT)) u_fls_host (
        .clk               (clk),
        .enable_program_in (en_pin),
        .flash_trigger_in  (trig),
        .flash_inhibit_in  (inh),
        .sink_low_in       (sink_low_in),
        .ovp_reached_in    (ovp_reached_in),
        .over_temp_in      (over_temp_in),
        .short_led_in      (short_led_in)
    );

    fls_ctrl #(
        .LAT_CYC  (LAT),
        .OFF_CYC  (OFF),
        .FLT_CYC  (FLT),
        .QSEC_CYC (QS)
    ) u_fls_ctrl (
        .clk               (clk),
        .resetn            (resetn),
        .enable_program_in (en_pin),
        .flash_trigger_in  (trig),
        .flash_inhibit_in  (inh),
        .sink_low_in       (sink_low_in),
        .ovp_reached_in    (ovp_reached_in),
        .over_temp_in      (over_temp_in),
        .short_led_in      (short_led_in),
        .device_on         (device_on),
        .flash_drive       (flash_drive),
        .flash_full        (flash_full),
        .movie_drive       (movie_drive),
        .led_level         (led_level),
        .flash_ratio       (flash_ratio),
        .test_current_on   (test_current_on),
        .output_connect    (output_connect),
        .fault_latched     (fault_latched)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run;
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask : tick

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({3'h0, got}, {3'h0, exp});
    endtask : chkb

    function automatic logic pick(input int k);
        case (k)
            0:       return flash_drive;
            default: return fault_latched;
        endcase
    endfunction : pick

    // bounded wait; running out ends the run
    task automatic wait_sig(input int k, input logic v, input int bound);
        int i;
        i = 0;
        while (pick(k) !== v && i < bound)
        begin
            tick(1);
            i++;
        end
        checks_done++;
        if (pick(k) !== v)
        begin
            n_mismatch++;
            $display("MISMATCH %0t wait on %0d", $time, k);
            complete_run();
        end
    endtask : wait_sig

    task automatic t_defaults;
        u_fls_host.burst(1);
        chkb(test_current_on, 1'b1);
        tick(2100);
        chkb(test_current_on, 1'b0);
        chkb(device_on, 1'b1);
        chkb(movie_drive, 1'b1);
        chk(led_level, 4'h0);
        chk({2'h0, flash_ratio}, 4'h0);
        u_fls_host.set_trig(1'b1);
        wait_sig(0, 1'b1, 10);
        chkb(movie_drive, 1'b0);
        chkb(flash_full, 1'b1);
        n = 0;
        while (flash_drive === 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        chkb(n >= 4 * QS - 5 && n <= 4 * QS + 5, 1'b1);
        u_fls_host.set_trig(1'b0);
        tick(10);
        chkb(movie_drive, 1'b0);
        u_fls_host.set_trig(1'b1);
        wait_sig(0, 1'b1, 10);
        u_fls_host.set_inh(1'b1);
        tick(8);
        chkb(flash_full, 1'b0);
        chk(led_level, 4'h0);
        u_fls_host.set_inh(1'b0);
        tick(8);
        chkb(flash_full, 1'b1);
        u_fls_host.set_trig(1'b0);
        wait_sig(0, 1'b0, 10);
    endtask : t_defaults

    task automatic t_program;
        u_fls_host.power_off(OFF + 10);
        chkb(device_on, 1'b0);
        u_fls_host.burst(6);
        tick(2100);
        chkb(movie_drive, 1'b1);
        chk(led_level, 4'h5);
        u_fls_host.write_reg(2, 2);
        chkb(movie_drive, 1'b0);
        u_fls_host.burst(3);
        chkb(movie_drive, 1'b1);
        u_fls_host.write_reg(3, 4);
        chk({2'h0, flash_ratio}, 4'h3);
        u_fls_host.burst(2);
        chk({2'h0, flash_ratio}, 4'h1);
        u_fls_host.burst(21);
        chk({2'h0, flash_ratio}, 4'h1);
        u_fls_host.burst(3);
        chk({2'h0, flash_ratio}, 4'h2);
        u_fls_host.write_reg(1, 2);
        u_fls_host.set_trig(1'b1);
        wait_sig(0, 1'b1, 10);
        n = 0;
        while (flash_drive === 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        chkb(n == QS, 1'b1);
        u_fls_host.set_trig(1'b0);
        tick(10);
        u_fls_host.write_reg(1, 1);
        u_fls_host.set_trig(1'b1);
        wait_sig(0, 1'b1, 10);
        tick(400);
        chkb(flash_drive, 1'b1);
        u_fls_host.write_reg(0, 11);
        chk(led_level, 4'ha);
        u_fls_host.set_inh(1'b1);
        tick(8);
        chk(led_level, 4'h0);
        u_fls_host.set_inh(1'b0);
        tick(8);
        chk(led_level, 4'ha);
        u_fls_host.set_trig(1'b0);
        wait_sig(0, 1'b0, 10);
        u_fls_host.power_off(OFF + 10);
        u_fls_host.burst(1);
        chk({2'h0, flash_ratio}, 4'h0);
    endtask : t_program

    task automatic t_faults;
        chkb(output_connect, 1'b1);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b1, 1'b0);
        tick(10);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b0, 1'b0);
        tick(FLT + 10);
        chkb(fault_latched, 1'b0);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b1, 1'b0);
        wait_sig(1, 1'b1, FLT + 12);
        chkb(output_connect, 1'b0);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b0, 1'b0);
        tick(20);
        chkb(fault_latched, 1'b1);
        u_fls_host.power_off(OFF + 10);
        u_fls_host.burst(1);
        chkb(fault_latched, 1'b0);
        u_fls_host.set_fault(1'b1, 1'b0, 1'b0, 1'b0);
        tick(FLT + 10);
        chkb(fault_latched, 1'b0);
        u_fls_host.set_fault(1'b1, 1'b1, 1'b0, 1'b0);
        wait_sig(1, 1'b1, FLT + 12);
        chkb(output_connect, 1'b0);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_faults

    task automatic t_short;
        u_fls_host.power_off(OFF + 10);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b0, 1'b1);
        u_fls_host.burst(1);
        chkb(test_current_on, 1'b1);
        tick(2100);
        u_fls_host.set_trig(1'b1);
        tick(10);
        chkb(flash_drive, 1'b0);
        chkb(movie_drive, 1'b0);
        u_fls_host.set_trig(1'b0);
        u_fls_host.set_fault(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_short

    initial
    begin
        resetn         = 1'b0;
        n_mismatch     = 0;
        checks_done    = 0;
        tick(3);
        resetn = 1'b1;
        t_defaults();
        t_program();
        t_faults();
        t_short();
        complete_run();
    end
endmodule : fls_ctrl_tb

//--- bench/fls_host.sv
`timescale 1ns/100ps
module fls_host #(
    parameter int LAT_CYC = 40
) (
    input  wire logic clk,
    output logic      enable_program_in,
    output logic      flash_trigger_in,
    output logic      flash_inhibit_in,
    output logic      sink_low_in,
    output logic      ovp_reached_in,
    output logic      over_temp_in,
    output logic      short_led_in
);
    initial
    begin
        enable_program_in = 1'b0;
        flash_trigger_in  = 1'b0;
        flash_inhibit_in  = 1'b0;
        sink_low_in       = 1'b0;
        ovp_reached_in    = 1'b0;
        over_temp_in      = 1'b0;
        short_led_in      = 1'b0;
    end

    // analog indicators seen by the block, driven as plain levels
    task automatic set_fault(input logic sl, input logic ov,
                             input logic ht, input logic sh);
        sink_low_in    = sl;
        ovp_reached_in = ov;
        over_temp_in   = ht;
        short_led_in   = sh;
    endtask : set_fault

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // each level held 3 cycles so the synchroniser compare settles
    task automatic burst(input int n);
        for (int i = 0; i < n; i++)
        begin
            enable_program_in = 1'b0;
            tick(3);
            enable_program_in = 1'b1;
            tick(3);
        end
        tick(LAT_CYC + 10);
    endtask : burst

    task automatic write_reg(input int a, input int d);
        burst(17 + a);
        burst(d);
    endtask : write_reg

    // pin falls back to its pull-down level while released
    task automatic power_off(input int n);
        enable_program_in = 1'b0;
        tick(n);
    endtask : power_off

    task automatic set_trig(input logic v);
        flash_trigger_in = v;
    endtask : set_trig

    task automatic set_inh(input logic v);
        flash_inhibit_in = v;
    endtask : set_inh
endmodule : fls_host

//--- rtl/fls_ctrl.sv
`timescale 1ns/100ps
module fls_ctrl #(
    parameter int LAT_CYC  = fls_pkg::LAT_CYC,
    parameter int OFF_CYC  = fls_pkg::OFF_CYC,
    parameter int FLT_CYC  = fls_pkg::FLT_CYC,
    parameter int QSEC_CYC = fls_pkg::QSEC_CYC
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       enable_program_in,
    input  wire logic       flash_trigger_in,
    input  wire logic       flash_inhibit_in,
    input  wire logic       sink_low_in,
    input  wire logic       ovp_reached_in,
    input  wire logic       over_temp_in,
    input  wire logic       short_led_in,
    output logic            device_on,
    output logic            flash_drive,
    output logic            flash_full,
    output logic            movie_drive,
    output logic [3:0]      led_level,
    output logic [1:0]      flash_ratio,
    output logic            test_current_on,
    output logic            output_connect,
    output logic            fault_latched
);
    logic [fls_pkg::N_PINS-1:0] pin_raw;
    logic [fls_pkg::N_PINS-1:0] pin_lvl;

    assign pin_raw = {short_led_in, over_temp_in, ovp_reached_in,
                      sink_low_in, flash_inhibit_in, flash_trigger_in,
                      enable_program_in};

    fls_sync #(.W(fls_pkg::N_PINS)) u_sync (
        .clk       (clk),
        .resetn    (resetn),
        .async_in  (pin_raw),
        .level_out (pin_lvl)
    );

    logic en_lvl, trig_lvl, inh_lvl, sinklo_lvl, ovp_lvl, hot_lvl, short_lvl;
    assign en_lvl     = pin_lvl[fls_pkg::PIN_EN];
    assign trig_lvl   = pin_lvl[fls_pkg::PIN_TRIG];
    assign inh_lvl    = pin_lvl[fls_pkg::PIN_INH];
    assign sinklo_lvl = pin_lvl[fls_pkg::PIN_SINKLO];
    assign ovp_lvl    = pin_lvl[fls_pkg::PIN_OVP];
    assign hot_lvl    = pin_lvl[fls_pkg::PIN_HOT];
    assign short_lvl  = pin_lvl[fls_pkg::PIN_SHORT];

    logic        en_prev_r;
    logic        trig_prev_r;
    logic        enabled_r;
    logic        enabled_prev_r;
    logic [16:0] off_cnt_r;
    logic [16:0] hi_cnt_r;
    logic [4:0]  edge_cnt_r;
    logic [1:0]  addr_r;
    logic [3:0]  reg_r [4];
    logic [3:0]  written_r;
    logic        en_rise;
    logic        trig_rise;
    logic        off_hit;
    logic        lat_hit;

    assign en_rise   = en_lvl && !en_prev_r;
    assign trig_rise = trig_lvl && !trig_prev_r;
    assign off_hit   = enabled_r && !en_lvl
                       && off_cnt_r == 17'(OFF_CYC - 1);
    assign lat_hit   = en_lvl && !en_rise && edge_cnt_r != 5'h00
                       && hi_cnt_r == 17'(LAT_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            en_prev_r      <= 1'b0;
            trig_prev_r    <= 1'b0;
            enabled_prev_r <= 1'b0;
        end
        else
        begin
            en_prev_r      <= en_lvl;
            trig_prev_r    <= trig_lvl;
            enabled_prev_r <= enabled_r;
        end
    end

    // device wakes on the first edge, sleeps after the off timeout
    always_ff @(posedge clk)
    begin
        if (!resetn)
            enabled_r <= 1'b0;
        else if (off_hit)
            enabled_r <= 1'b0;
        else if (en_rise)
            enabled_r <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn || en_lvl || !enabled_r)
            off_cnt_r <= 17'h00000;
        else
            off_cnt_r <= off_cnt_r + 17'h00001;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn || en_rise || !en_lvl || lat_hit)
            hi_cnt_r <= 17'h00000;
        else if (edge_cnt_r != 5'h00)
            hi_cnt_r <= hi_cnt_r + 17'h00001;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn || off_hit)
        begin
            edge_cnt_r <= 5'h00;
            addr_r     <= fls_pkg::ADDR_MOVIE;
            written_r  <= 4'h0;
            for (int k = 0; k < 4; k++)
                reg_r[k] <= 4'h0;
        end
        else if (en_rise)
        begin
            if (edge_cnt_r != fls_pkg::EDGE_MAX)
                edge_cnt_r <= edge_cnt_r + 5'h01;
            if (!enabled_r)
                addr_r <= fls_pkg::ADDR_MOVIE;
        end
        else if (lat_hit)
        begin
            edge_cnt_r <= 5'h00;
            if (edge_cnt_r <= fls_pkg::EDGE_DATA_MAX)
            begin
                // address kept, so repeated data bursts need no resend
                reg_r[addr_r]     <= 4'(edge_cnt_r - 5'h01);
                written_r[addr_r] <= 1'b1;
            end
            else if (edge_cnt_r <= fls_pkg::EDGE_ADDR_HI)
                addr_r <= 2'(edge_cnt_r - fls_pkg::EDGE_ADDR_LO);
        end
    end

    logic [3:0] movie_code;
    logic [3:0] timer_code;
    logic [3:0] oe_code;
    logic [3:0] ratio_code;

    assign movie_code = written_r[fls_pkg::ADDR_MOVIE]
                        ? reg_r[fls_pkg::ADDR_MOVIE] : fls_pkg::DEF_MOVIE;
    assign timer_code = written_r[fls_pkg::ADDR_TIMER]
                        ? reg_r[fls_pkg::ADDR_TIMER] : fls_pkg::DEF_TIMER;
    assign oe_code    = written_r[fls_pkg::ADDR_OE]
                        ? reg_r[fls_pkg::ADDR_OE] : fls_pkg::DEF_OE;
    assign ratio_code = written_r[fls_pkg::ADDR_RATIO]
                        ? reg_r[fls_pkg::ADDR_RATIO] : fls_pkg::DEF_RATIO;

    logic        timer_on;
    logic [3:0]  timer_q;
    logic [26:0] safe_lim;
    logic        movie_oe;

    // codes above 7 have no meaning; clamp them to the longest time
    assign timer_on = timer_code != fls_pkg::TIMER_OFF;
    assign timer_q  = (timer_code > fls_pkg::TIMER_MAXQ)
                      ? fls_pkg::TIMER_MAXQ : timer_code;
    assign safe_lim = 27'(QSEC_CYC) * 27'(timer_q);
    assign movie_oe = oe_code >= fls_pkg::OE_ON_MIN;

    logic [11:0] test_cnt_r;
    logic        testing_r;
    logic        short_r;

    always_ff @(posedge clk)
    begin
        if (!resetn || !enabled_r)
        begin
            test_cnt_r <= 12'h000;
            testing_r  <= 1'b0;
            short_r    <= 1'b0;
        end
        else if (!enabled_prev_r)
        begin
            testing_r  <= 1'b1;
            test_cnt_r <= 12'h000;
        end
        else if (testing_r)
        begin
            if (test_cnt_r == 12'(fls_pkg::TEST_CYC - 1))
            begin
                testing_r <= 1'b0;
                short_r   <= short_lvl;
            end
            else
                test_cnt_r <= test_cnt_r + 12'h001;
        end
    end

    logic [16:0] open_cnt_r;
    logic [16:0] hot_cnt_r;
    logic        latched_r;

    // either fault latches once it persists; a glitch restarts its count
    always_ff @(posedge clk)
    begin
        if (!resetn || !enabled_r)
        begin
            open_cnt_r <= 17'h00000;
            hot_cnt_r  <= 17'h00000;
            latched_r  <= 1'b0;
        end
        else
        begin
            if (!(sinklo_lvl && ovp_lvl))
                open_cnt_r <= 17'h00000;
            else if (open_cnt_r != 17'(FLT_CYC))
                open_cnt_r <= open_cnt_r + 17'h00001;
            if (!hot_lvl)
                hot_cnt_r <= 17'h00000;
            else if (hot_cnt_r != 17'(FLT_CYC))
                hot_cnt_r <= hot_cnt_r + 17'h00001;
            if (open_cnt_r == 17'(FLT_CYC)
                || hot_cnt_r == 17'(FLT_CYC))
                latched_r <= 1'b1;
        end
    end

    logic                 run_ok;
    fls_pkg::fls_fstate_t fstate_r;
    logic [26:0]          safe_cnt_r;

    assign run_ok = enabled_r && !latched_r && !short_r && !testing_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            fstate_r   <= fls_pkg::FS_IDLE;
            safe_cnt_r <= 27'h0000000;
        end
        else
        begin
            unique case (fstate_r)
                fls_pkg::FS_IDLE, fls_pkg::FS_DONE:
                begin
                    safe_cnt_r <= 27'h0000000;
                    if (run_ok && trig_rise)
                        fstate_r <= fls_pkg::FS_FLASH;
                    else if (!enabled_r)
                        fstate_r <= fls_pkg::FS_IDLE;
                end
                fls_pkg::FS_FLASH:
                begin
                    safe_cnt_r <= safe_cnt_r + 27'h0000001;
                    if (!trig_lvl || !run_ok
                        || (timer_on && safe_cnt_r == safe_lim - 27'h1))
                        fstate_r <= fls_pkg::FS_DONE;
                end
                default:
                    fstate_r <= fls_pkg::FS_IDLE;
            endcase
        end
    end

    logic in_flash;
    assign in_flash = fstate_r == fls_pkg::FS_FLASH;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            flash_drive     <= 1'b0;
            flash_full      <= 1'b0;
            movie_drive     <= 1'b0;
            led_level       <= fls_pkg::DEF_MOVIE;
            flash_ratio     <= 2'h0;
            test_current_on <= 1'b0;
            output_connect  <= 1'b0;
            fault_latched   <= 1'b0;
            device_on       <= 1'b0;
        end
        else
        begin
            flash_drive     <= in_flash;
            flash_full      <= in_flash && !inh_lvl;
            movie_drive     <= run_ok && !in_flash && movie_oe
                               && fstate_r != fls_pkg::FS_DONE;
            // level tracks writes even mid-flash, except while inhibit forces DEF_MOVIE
            led_level       <= (in_flash && inh_lvl)
                               ? fls_pkg::DEF_MOVIE : movie_code;
            flash_ratio     <= (ratio_code > fls_pkg::RATIO_MAX)
                               ? 2'h3 : ratio_code[1:0];
            test_current_on <= testing_r;
            output_connect  <= enabled_r && !latched_r;
            fault_latched   <= latched_r;
            device_on       <= enabled_r;
        end
    end

    property p_flash_start;
        @(posedge clk) disable iff (!resetn)
        (run_ok && trig_rise && !in_flash) |=> in_flash ##1 flash_drive;
    endproperty
    a_flash_start: assert property (p_flash_start)
        else $error("flash did not start on trigger edge");

    property p_inhibit;
        @(posedge clk) disable iff (!resetn)
        (in_flash && inh_lvl) |=> (!flash_full
                                   && led_level == fls_pkg::DEF_MOVIE);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit did not reduce flash current");

    property p_priority;
        @(posedge clk) disable iff (!resetn)
        flash_drive |-> !movie_drive;
    endproperty
    a_priority: assert property (p_priority)
        else $error("movie drive active during flash");

    property p_no_return;
        @(posedge clk) disable iff (!resetn)
        (fstate_r == fls_pkg::FS_DONE && enabled_r) |=> !movie_drive;
    endproperty
    a_no_return: assert property (p_no_return)
        else $error("movie mode resumed after flash");

    property p_latch_off;
        @(posedge clk) disable iff (!resetn)
        $rose(latched_r) |=> (!output_connect && fault_latched)
                             ##1 (latched_r || !enabled_r);
    endproperty
    a_latch_off: assert property (p_latch_off)
        else $error("fault latch did not disconnect output");

    property p_flash_end;
        @(posedge clk) disable iff (!resetn)
        (in_flash && !trig_lvl) |=> !in_flash ##1 !flash_drive;
    endproperty
    a_flash_end: assert property (p_flash_end)
        else $error("flash outlived trigger");

    property p_addr;
        @(posedge clk) disable iff (!resetn)
        (lat_hit && edge_cnt_r >= fls_pkg::EDGE_ADDR_LO
         && edge_cnt_r <= fls_pkg::EDGE_ADDR_HI)
        |=> addr_r == 2'($past(edge_cnt_r) - fls_pkg::EDGE_ADDR_LO);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address burst decoded wrongly");

    property p_data;
        @(posedge clk) disable iff (!resetn)
        (lat_hit && edge_cnt_r <= fls_pkg::EDGE_DATA_MAX)
        |=> reg_r[$past(addr_r)] == 4'($past(edge_cnt_r) - 5'h01);
    endproperty
    a_data: assert property (p_data)
        else $error("data burst not stored");

    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        off_hit |=> (written_r == 4'h0 && addr_r == fls_pkg::ADDR_MOVIE
                     && !enabled_r) ##1 !device_on;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not clear registers");
endmodule : fls_ctrl

//--- rtl/fls_pkg.sv
package fls_pkg;
    localparam int CLK_KHZ     = 40000;
    localparam int T_LAT_US    = 500;
    localparam int T_OFF_US    = 500;
    localparam int T_FLT_US    = 1400;
    localparam int T_QSEC_MS   = 250;
    localparam int T_TEST_US   = 50;
    localparam int LAT_CYC     = T_LAT_US * CLK_KHZ / 1000;
    localparam int OFF_CYC     = T_OFF_US * CLK_KHZ / 1000;
    localparam int FLT_CYC     = T_FLT_US * CLK_KHZ / 1000;
    localparam int QSEC_CYC    = T_QSEC_MS * CLK_KHZ;
    localparam int TEST_CYC    = T_TEST_US * CLK_KHZ / 1000;

    localparam int N_PINS      = 7;
    localparam int PIN_EN      = 0;
    localparam int PIN_TRIG    = 1;
    localparam int PIN_INH     = 2;
    localparam int PIN_SINKLO  = 3;
    localparam int PIN_OVP     = 4;
    localparam int PIN_HOT     = 5;
    localparam int PIN_SHORT   = 6;

    localparam logic [4:0] EDGE_MAX      = 5'h1f;
    localparam logic [4:0] EDGE_DATA_MAX = 5'h10;
    localparam logic [4:0] EDGE_ADDR_LO  = 5'h11;
    localparam logic [4:0] EDGE_ADDR_HI  = 5'h14;

    localparam logic [1:0] ADDR_MOVIE  = 2'h0;
    localparam logic [1:0] ADDR_TIMER  = 2'h1;
    localparam logic [1:0] ADDR_OE     = 2'h2;
    localparam logic [1:0] ADDR_RATIO  = 2'h3;

    // stored code is the burst length minus one
    localparam logic [3:0] DEF_MOVIE   = 4'h0;
    localparam logic [3:0] DEF_TIMER   = 4'h4;
    localparam logic [3:0] DEF_OE      = 4'h3;
    localparam logic [3:0] DEF_RATIO   = 4'h0;
    localparam logic [3:0] TIMER_OFF   = 4'h0;
    localparam logic [3:0] TIMER_MAXQ  = 4'h7;
    localparam logic [3:0] OE_ON_MIN   = 4'h2;
    localparam logic [3:0] RATIO_MAX   = 4'h3;

    typedef enum logic [1:0] {
        FS_IDLE  = 2'b00,
        FS_FLASH = 2'b01,
        FS_DONE  = 2'b10
    } fls_fstate_t;
endpackage : fls_pkg

//--- rtl/fls_sync.sv
`timescale 1ns/100ps
module fls_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // level moves only once stages two and three agree
            always_ff @(posedge clk)
            begin
                if (!resetn)
                begin
                    s1_r[i]      <= 1'b0;
                    s2_r[i]      <= 1'b0;
                    s3_r[i]      <= 1'b0;
                    level_out[i] <= 1'b0;
                end
                else
                begin
                    s1_r[i] <= async_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i])
                        level_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule : fls_sync
